// *** hdl/can_filt_defs.svh ***
// Constant definitions for the acceptance filter and frame path.
`ifndef CAN_FILT_DEFS_SVH
`define CAN_FILT_DEFS_SVH
`define ENTRY_COUNT 32
`define ENTRY_IDX_W 5
`define STD_ID_W 11
`define EXT_ID_W 29
`define STD_ID_MASK 29'h00007ff
`define EXT_ID_MASK 29'h1fffffff
`define MAX_LEN 4'h8
`define RX_DEPTH 8
`define RX_PTR_W 3
`define RX_CNT_W 4
`define PORT_COUNT 2
`endif

// *** hdl/can_filt_pkg.sv ***
// Types shared by the acceptance filter and frame path.
package can_filt_pkg;
  // One filter entry as stored in the bank.
  typedef struct packed {
    logic        used;
    logic        ext;
    logic [28:0] id;
    logic [28:0] mask;
  } filt_entry_t;
  // One queued received frame.
  typedef struct packed {
    logic [28:0] id;
    logic        ext;
    logic        rtr;
    logic [3:0]  len;
    logic [63:0] data;
    logic [4:0]  hit;
  } rx_frame_t;
  // Transmit state walked in Gray order.
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } tx_state_t;
endpackage : can_filt_pkg

// *** hdl/can_acceptance_filter_rx_tx.sv ***
// Acceptance filter bank, receive queue and transmit frame loader.
`timescale 1ns/1ps
`include "can_filt_defs.svh"
module can_acceptance_filter_rx_tx (
  // Clock and reset.
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  // Filter programming.
  input  wire logic        prog_valid_in,
  input  wire logic        prog_port_in,
  input  wire logic [4:0]  prog_index_in,
  input  wire logic [28:0] prog_id_in,
  input  wire logic [28:0] prog_mask_in,
  input  wire logic        prog_ext_in,
  input  wire logic        catch_all_in,
  input  wire logic        catch_port_in,
  // Received frame from the protocol engine, one per port.
  input  wire logic [1:0]  rx_valid_in,
  input  wire logic [57:0] rx_id_in,
  input  wire logic [1:0]  rx_ext_in,
  input  wire logic [1:0]  rx_rtr_in,
  input  wire logic [7:0]  rx_len_in,
  input  wire logic [127:0] rx_data_in,
  // Host fetch.
  input  wire logic        fetch_port_in,
  input  wire logic        fetch_in,
  output logic [1:0]       pending_out,
  output logic             fetch_valid_out,
  output logic [28:0]      fetch_id_out,
  output logic             fetch_ext_out,
  output logic             fetch_rtr_out,
  output logic [3:0]       fetch_len_out,
  output logic [63:0]      fetch_data_out,
  output logic [4:0]       fetch_entry_out,
  // Transmit load.
  input  wire logic        tx_req_in,
  input  wire logic [28:0] tx_id_in,
  input  wire logic        tx_ext_in,
  input  wire logic        tx_rtr_in,
  input  wire logic [7:0]  tx_len_in,
  input  wire logic [63:0] tx_data_in,
  input  wire logic        tx_ready_in,
  output logic             tx_busy_out,
  output logic             tx_valid_out,
  output logic [28:0]      tx_id_out,
  output logic             tx_ext_out,
  output logic             tx_rtr_out,
  output logic [3:0]       tx_len_out,
  output logic [63:0]      tx_data_out
);

  // ****************************************************************
  // Whole-module state
  // ****************************************************************
  typedef struct packed {
    can_filt_pkg::filt_entry_t [1:0][31:0] bank;  // Filter banks, one per port.
    can_filt_pkg::rx_frame_t [1:0][7:0]   fifo;  // Receive queues.
    logic [1:0][2:0]                       wr;    // Write pointers.
    logic [1:0][2:0]                       rd;    // Read pointers.
    logic [1:0][3:0]                       cnt;   // Queue occupancy.
    logic                                  fv;    // Fetch answer valid.
    can_filt_pkg::rx_frame_t               fo;    // Fetch answer.
    can_filt_pkg::tx_state_t               txs;   // Transmit state.
    can_filt_pkg::rx_frame_t               to;    // Frame being sent.
  } state_t;

  state_t s_q;
  state_t s_d;

  // Keeps only the bytes below the length; used on both paths.
  function automatic logic [63:0] trim_data(input logic [63:0] d, input logic [3:0] n);
    logic [63:0] r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      if (4'(b) < n) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : trim_data

  // Clamps a length to eight bytes.
  function automatic logic [3:0] clamp_len(input logic [7:0] l);
    return (l > 8'h08) ? `MAX_LEN : l[3:0];
  endfunction : clamp_len

  // ****************************************************************
  // Match vectors per port and entry
  // ****************************************************************
  logic [1:0][31:0] hit_v;  // Entry hit flags.
  genvar gp, ge;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      for (ge = 0; ge < 32; ge++) begin : g_ent
        // Unused entries never hit, so reset banks accept nothing.
        assign hit_v[gp][ge] = s_q.bank[gp][ge].used &&
          (s_q.bank[gp][ge].ext == rx_ext_in[gp]) &&
          (((rx_id_in[gp*29 +: 29] ^ s_q.bank[gp][ge].id) &
            s_q.bank[gp][ge].mask) == 29'h0);
      end
    end
  endgenerate

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [28:0] idm;
    logic        found;
    logic [4:0]  win;
    logic [3:0]  ln;
    s_d = s_q;
    idm = '0;
    found = 1'b0;
    win = '0;
    ln = '0;
    s_d.fv = 1'b0;
    // Programming writes one entry; standard entries keep eleven bits.
    if (prog_valid_in) begin
      idm = prog_ext_in ? `EXT_ID_MASK : `STD_ID_MASK;
      s_d.bank[prog_port_in][prog_index_in] = '{1'b1, prog_ext_in,
        prog_id_in & idm, prog_mask_in & idm};
    end
    // Catch command fills the top two entries so specific ones win.
    if (catch_all_in) begin
      s_d.bank[catch_port_in][31] = '{1'b1, 1'b1, 29'h0, 29'h0};
      s_d.bank[catch_port_in][30] = '{1'b1, 1'b0, 29'h0, 29'h0};
    end
    // Fetch pops the oldest frame of the chosen port.
    if (fetch_in && s_q.cnt[fetch_port_in] != 4'h0) begin
      s_d.fo = s_q.fifo[fetch_port_in][s_q.rd[fetch_port_in]];
      s_d.fv = 1'b1;
      s_d.rd[fetch_port_in] = s_q.rd[fetch_port_in] + 3'h1;
      s_d.cnt[fetch_port_in] = s_q.cnt[fetch_port_in] - 4'h1;
    end
    // Each port queues an accepted frame; a full queue drops it unless a fetch on that port frees a slot in the same cycle.
    for (int p = 0; p < 2; p++) begin
      found = 1'b0;
      win = '0;
      for (int e = 31; e >= 0; e--) begin
        if (hit_v[p][e]) begin
          found = 1'b1;
          win = 5'(e);
        end
      end
      if (rx_valid_in[p] && found && s_d.cnt[p] != 4'h8) begin
        ln = clamp_len(rx_len_in[p*4 +: 4] == 4'h0 ? 8'h0 : {4'h0, rx_len_in[p*4 +: 4]});
        idm = rx_ext_in[p] ? `EXT_ID_MASK : `STD_ID_MASK;
        s_d.fifo[p][s_q.wr[p]] = '{rx_id_in[p*29 +: 29] & idm, rx_ext_in[p], rx_rtr_in[p],
          ln, trim_data(rx_data_in[p*64 +: 64], ln), win};
        s_d.wr[p] = s_q.wr[p] + 3'h1;
        s_d.cnt[p] = s_d.cnt[p] + 4'h1;
      end
    end
    // Transmit: a request seen in TX_IDLE latches a whole fresh frame; requests during TX_SEND are ignored.
    case (s_q.txs)
      can_filt_pkg::TX_IDLE: begin
        if (tx_req_in) begin
          ln = clamp_len(tx_len_in);
          // Standard frames never carry stray upper identifier bits onto the bus.
          idm = tx_ext_in ? `EXT_ID_MASK : `STD_ID_MASK;
          s_d.to = '{tx_id_in & idm, tx_ext_in, tx_rtr_in, ln,
            tx_rtr_in ? 64'h0 : trim_data(tx_data_in, ln), 5'h0};
          s_d.txs = can_filt_pkg::TX_SEND;
        end
      end
      can_filt_pkg::TX_SEND: begin
        if (tx_ready_in) begin
          s_d.txs = can_filt_pkg::TX_IDLE;
        end
      end
      default: begin
        s_d.txs = can_filt_pkg::TX_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs, all from flip-flops, the handshakes included.
  assign pending_out[0]  = (s_q.cnt[0] != 4'h0);
  assign pending_out[1]  = (s_q.cnt[1] != 4'h0);
  assign fetch_valid_out = s_q.fv;
  assign fetch_id_out    = s_q.fo.id;
  assign fetch_ext_out   = s_q.fo.ext;
  assign fetch_rtr_out   = s_q.fo.rtr;
  assign fetch_len_out   = s_q.fo.len;
  assign fetch_data_out  = s_q.fo.data;
  assign fetch_entry_out = s_q.fo.hit;
  assign tx_busy_out     = (s_q.txs != can_filt_pkg::TX_IDLE);
  assign tx_valid_out    = (s_q.txs == can_filt_pkg::TX_SEND);
  assign tx_id_out       = s_q.to.id;
  assign tx_ext_out      = s_q.to.ext;
  assign tx_rtr_out      = s_q.to.rtr;
  assign tx_len_out      = s_q.to.len;
  assign tx_data_out     = s_q.to.data;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  rtr_zero_a: assert property (tx_valid_out && tx_rtr_out |-> tx_data_out == 64'h0)
    else $error("Remote frame carries data.");
  len_clamp_a: assert property (tx_valid_out |-> tx_len_out <= 4'h8)
    else $error("Transmit length above eight.");
  fetch_len_a: assert property (fetch_valid_out |-> fetch_len_out <= 4'h8)
    else $error("Fetched length above eight.");
  fetch_ans_a: assert property (
    fetch_in && pending_out[fetch_port_in] |=> fetch_valid_out)
    else $error("Fetch gave no answer.");
  fetch_none_a: assert property (
    fetch_in && !pending_out[fetch_port_in] |=> !fetch_valid_out)
    else $error("Fetch answered from empty queue.");
  tx_load_a: assert property (!tx_busy_out && tx_req_in |=>
    tx_valid_out && tx_len_out == clamp_len($past(tx_len_in)))
    else $error("Transmit frame not loaded.");
  std_id_a: assert property (
    fetch_valid_out && !fetch_ext_out |-> fetch_id_out[28:11] == 18'h0)
    else $error("Standard ID wider than eleven bits.");
  empty_rx_a: assert property (pending_out == 2'b00 && rx_valid_in == 2'b00
    && !fetch_in |=> pending_out == 2'b00)
    else $error("Pending raised with no frame.");

  fetch_c: cover property (fetch_valid_out);
  tx_c: cover property (tx_valid_out && tx_ready_in);
  catch_c: cover property (catch_all_in);
  full_c: cover property (s_q.cnt[0] == 4'h8);

endmodule : can_acceptance_filter_rx_tx

// *** test/can_bus_node.sv ***
// Far-side bus node model: feeds received frames and takes transmitted ones.
`timescale 1ns/1ps
module can_bus_node (
  // Clock.
  input  wire logic         clk_in,
  // Frames leaving the block.
  input  wire logic         tx_valid_in,
  input  wire logic [28:0]  tx_id_in,
  input  wire logic [3:0]   tx_len_in,
  input  wire logic [63:0]  tx_data_in,
  output logic              tx_ready_out,
  // Frames arriving at the block.
  output logic [1:0]        rx_valid_out,
  output logic [57:0]       rx_id_out,
  output logic [1:0]        rx_ext_out,
  output logic [7:0]        rx_len_out,
  output logic [127:0]      rx_data_out
);
  int          stall = 0;  // Cycles that ready is held back per frame.
  int          wait_q = 0; // Cycles the current frame has waited.
  int          seen = 0;   // Frames taken so far.
  logic [28:0] got_id;     // Last frame taken.
  logic [3:0]  got_len;
  logic [63:0] got_data;
  initial begin
    {tx_ready_out, rx_valid_out, rx_id_out, rx_ext_out, rx_len_out, rx_data_out} = '0;
  end
  // A frame counts as taken only at the edge where ready is seen high.
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      {got_id, got_len, got_data} = {tx_id_in, tx_len_in, tx_data_in};
      seen++;
    end
    #1;
    tx_ready_out = tx_valid_in && !tx_ready_out && wait_q >= stall;
    wait_q = tx_valid_in ? wait_q + 1 : 0;
  end
  // One frame for one cycle; afterwards the id, ext and data lines flip so stale values never look valid.
  task automatic send(input int p, input logic [28:0] id, input logic ext,
                      input logic [3:0] len, input logic [63:0] d);
    rx_id_out[p*29+:29] = id;
    rx_ext_out[p] = ext;
    rx_len_out[p*4+:4] = len;
    rx_data_out[p*64+:64] = d;
    rx_valid_out[p] = 1'b1;
    @(posedge clk_in);
    #1;
    rx_valid_out[p] = 1'b0;
    {rx_id_out, rx_ext_out, rx_data_out} = ~{rx_id_out, rx_ext_out, rx_data_out};
  endtask : send
endmodule : can_bus_node

// *** test/tb.sv ***
// Self-checking bench for the acceptance filter, receive queue and transmit loader.
`timescale 1ns/1ps
module tb;
  localparam logic [63:0] pay_c = 64'h8877665544332211; // Payload of every received frame.
  logic sys_clk_in = 0, rst_b_in = 0, prog_valid_in, prog_port_in, prog_ext_in, catch_all_in;
  logic catch_port_in, fetch_port_in, fetch_in, tx_req_in, tx_ext_in, tx_rtr_in, tx_ready_in;
  logic [4:0] prog_index_in, fetch_entry_out;
  logic [28:0] prog_id_in, prog_mask_in, tx_id_in, fetch_id_out, tx_id_out;
  logic [1:0] rx_valid_in, rx_ext_in, pending_out;
  logic [1:0] rx_rtr_in = 2'h0; // Remote flag on receive is not exercised.
  logic [57:0] rx_id_in;
  logic [7:0] rx_len_in, tx_len_in;
  logic [127:0] rx_data_in;
  logic [63:0] tx_data_in, fetch_data_out, tx_data_out;
  logic [3:0] fetch_len_out, tx_len_out;
  logic fetch_valid_out, fetch_ext_out, fetch_rtr_out, tx_busy_out, tx_valid_out;
  logic tx_ext_out, tx_rtr_out;
  int err_total = 0, checks_done = 0;
  can_acceptance_filter_rx_tx can_acceptance_filter_rx_tx_i (.*);
  can_bus_node can_bus_node_i (.clk_in(sys_clk_in), .tx_valid_in(tx_valid_out),
    .tx_id_in(tx_id_out), .tx_len_in(tx_len_out), .tx_data_in(tx_data_out),
    .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in), .rx_id_out(rx_id_in),
    .rx_ext_out(rx_ext_in), .rx_len_out(rx_len_in), .rx_data_out(rx_data_in));
  always #2 sys_clk_in = ~sys_clk_in;
  // ********************
  // Shared helpers
  // ********************
  task automatic chk(input logic [63:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Inputs always move 1 ns after the edge, clear of the sampling point.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic prog(input int i, input logic [28:0] id, m, input logic ext);
    {prog_port_in, prog_index_in} = {1'b0, i[4:0]};
    {prog_id_in, prog_mask_in, prog_ext_in} = {id, m, ext};
    prog_valid_in = 1;
    tick(1);
    prog_valid_in = 0;
    // One idle edge, so a following call never lowers and raises the strobe in one step.
    tick(1);
  endtask : prog
  task automatic fet(input int p, input logic [28:0] id, input logic ext,
                     input logic [3:0] len, input logic [4:0] ent);
    fetch_port_in = p[0];
    fetch_in = 1;
    tick(1);
    fetch_in = 0;
    chk(fetch_valid_out, 1);
    chk(fetch_id_out, id);
    chk(fetch_ext_out, ext);
    chk(fetch_rtr_out, 0);
    chk(fetch_len_out, len);
    chk(fetch_entry_out, ent);
    chk(fetch_data_out, pay_c & ~({64{1'b1}} << (8 * len)));
  endtask : fet
  // One frame in; when it should pass, fetch it and see the queue empty again.
  task automatic rx(input int p, input logic [28:0] id, input logic ext,
                    input logic [3:0] len, input logic hit, input logic [4:0] ent);
    can_bus_node_i.send(p, id, ext, len, pay_c);
    tick(1);
    chk(pending_out[p], hit);
    if (hit) begin
      fet(p, id, ext, len, ent);
      chk(pending_out[p], 0);
    end
  endtask : rx
  // Send one frame, let the far side stall, then judge what it received.
  task automatic tx(input logic rtr, input logic [7:0] len, input logic [63:0] d, exp_d,
                    input int stall);
    int n;
    n = can_bus_node_i.seen;
    can_bus_node_i.stall = stall;
    {tx_id_in, tx_ext_in, tx_rtr_in} = {29'h25a, 1'b0, rtr};
    {tx_len_in, tx_data_in} = {len, d};
    tx_req_in = 1;
    tick(1);
    tx_req_in = 0;
    chk(tx_busy_out, 1);
    chk(tx_ext_out, 0);
    chk(tx_rtr_out, rtr);
    for (int i = 0; i < 50 && can_bus_node_i.seen == n; i++) tick(1);
    chk(can_bus_node_i.seen, n + 1);
    chk(tx_busy_out, 0);
    chk(can_bus_node_i.got_id, 29'h25a);
    chk(can_bus_node_i.got_len, len > 8 ? 8 : len);
    chk(can_bus_node_i.got_data, exp_d);
    tick(1);
  endtask : tx
  // ********************
  // Scenarios
  // ********************
  task automatic t_filter;
    rx(0, 29'h232, 0, 8, 0, 0);
    rx(1, 29'h1abcdef, 1, 8, 0, 0);
    prog(0, 29'h230, 29'h7f0, 0);
    prog(1, 29'h18ff50e5, 29'h1fffffff, 1);
    prog(2, 29'h1ffff555, 29'h1fffffff, 0);
    rx(0, 29'h23a, 0, 2, 1, 0);
    rx(0, 29'h33a, 0, 8, 0, 0);
    rx(0, 29'h0e5, 0, 8, 0, 0);
    rx(0, 29'h18ff50e5, 1, 0, 1, 1);
    rx(0, 29'h18ff50e4, 1, 8, 0, 0);
    rx(0, 29'h555, 0, 8, 1, 2);
    rx(1, 29'h23a, 0, 8, 0, 0);
  endtask : t_filter
  // Two frames in a row must come out oldest first; an empty queue gives no answer.
  task automatic t_queue;
    can_bus_node_i.send(0, 29'h231, 0, 1, pay_c);
    tick(1);
    can_bus_node_i.send(0, 29'h23f, 0, 4, pay_c);
    tick(1);
    chk(pending_out[0], 1);
    fet(0, 29'h231, 0, 1, 0);
    tick(1);
    fet(0, 29'h23f, 0, 4, 0);
    tick(1);
    chk(pending_out[0], 0);
    fetch_port_in = 1'b0;
    fetch_in = 1;
    tick(1);
    fetch_in = 0;
    chk(fetch_valid_out, 0);
  endtask : t_queue
  task automatic t_catch;
    catch_port_in = 0;
    catch_all_in = 1;
    tick(1);
    catch_all_in = 0;
    rx(0, 29'h232, 0, 8, 1, 0);
    rx(0, 29'h7ff, 0, 3, 1, 30);
    rx(0, 29'h1234567, 1, 8, 1, 31);
    // The second port's catch-alls work apart from the first port's bank.
    catch_port_in = 1;
    catch_all_in = 1;
    tick(1);
    catch_all_in = 0;
    rx(1, 29'h23a, 0, 8, 1, 30);
  endtask : t_catch
  task automatic t_tx;
    tx(0, 8'h01, 64'h1122334455667780, 64'h80, 0);
    tx(0, 8'h01, 64'h1122334455667781, 64'h81, 3);
    tx(0, 8'h0c, pay_c, pay_c, 2);
    tx(1, 8'h08, pay_c, 64'h0, 1);
  endtask : t_tx
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    {prog_valid_in, prog_port_in, prog_index_in, prog_id_in, prog_mask_in, prog_ext_in} = '0;
    {catch_all_in, catch_port_in, fetch_port_in, fetch_in} = '0;
    {tx_req_in, tx_id_in, tx_ext_in, tx_rtr_in, tx_len_in, tx_data_in} = '0;
    tick(8);
    rst_b_in = 1;
    t_filter();
    t_queue();
    t_catch();
    t_tx();
    report_and_stop();
  end
  // Whole run needs well under 1000 cycles; a hang is cut off far beyond that.
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
endmodule : tb
